// ### core/dcd_pkg.sv
// Purpose: constants and carriers for the debug command decoder
// Assumes: one clock, the debug clock, at 25 MHz
// Notes:   cycle figures are debug-clock counts

package dcd_pkg;

    // ***************************************************************
    // command opcodes
    // ***************************************************************
    localparam logic [7:0] DCD_OP_BACKGROUND   = 8'h90;
    localparam logic [7:0] DCD_OP_READ_INMAP_B = 8'hE4;
    localparam logic [7:0] DCD_OP_READ_INMAP_W = 8'hEC;
    localparam logic [7:0] DCD_OP_READ_B       = 8'hE0;
    localparam logic [7:0] DCD_OP_READ_W       = 8'hE8;
    localparam logic [7:0] DCD_OP_WRITE_INMAP_B = 8'hC4;
    localparam logic [7:0] DCD_OP_WRITE_INMAP_W = 8'hCC;
    localparam logic [7:0] DCD_OP_WRITE_B      = 8'hC0;
    localparam logic [7:0] DCD_OP_WRITE_W      = 8'hC8;
    localparam logic [7:0] DCD_OP_FW_RD_FIRST  = 8'h62;
    localparam logic [7:0] DCD_OP_FW_RD_LAST   = 8'h67;
    localparam logic [7:0] DCD_OP_FW_WR_FIRST  = 8'h42;
    localparam logic [7:0] DCD_OP_FW_WR_LAST   = 8'h47;
    localparam logic [7:0] DCD_OP_RESUME       = 8'h08;
    localparam logic [7:0] DCD_OP_SINGLE_STEP  = 8'h10;
    localparam logic [7:0] DCD_OP_TAG_RESUME   = 8'h18;

    // ***************************************************************
    // debug resource map
    // ***************************************************************
    localparam logic [15:0] DCD_ROM_FIRST = 16'hFF20;
    localparam logic [15:0] DCD_ROM_LAST  = 16'hFFFF;
    localparam logic [15:0] DCD_REG_FIRST = 16'hFF00;
    localparam logic [15:0] DCD_REG_LAST  = 16'hFF06;

    // ***************************************************************
    // timing in debug-clock cycles, and frame lengths in bits
    // ***************************************************************
    localparam logic [9:0] DCD_SAMPLE_CYC   = 10'd10;
    localparam logic [9:0] DCD_SPEEDUP1_CYC = 10'd7;
    localparam logic [9:0] DCD_LOW0_CYC     = 10'd13;
    localparam logic [9:0] DCD_BITEND_CYC   = 10'd14;
    localparam logic [9:0] DCD_TIMEOUT_CYC  = 10'd512;
    localparam logic [7:0] DCD_STEAL_CYC    = 8'd128;
    localparam logic [4:0] DCD_OPC_BITS     = 5'd8;
    localparam logic [4:0] DCD_WORD_BITS    = 5'd16;

    // ***************************************************************
    // reset values
    // ***************************************************************
    localparam logic [15:0] DCD_SHIFT_RST = 16'h0000;

    typedef enum logic [2:0] {
        DCD_S_OPC   = 3'b000,
        DCD_S_ADDR  = 3'b001,
        DCD_S_WDATA = 3'b010,
        DCD_S_EXEC  = 3'b011,
        DCD_S_FWRD  = 3'b100,
        DCD_S_RDATA = 3'b101
    } dcd_state_e;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic [1:0]  byte_en;
        logic        write;
        logic        inmap;
        logic        tgt_rom;
        logic        tgt_reg;
    } dcd_mem_req_s;

    typedef struct packed {
        logic [7:0]  opcode;
        logic [15:0] data;
    } dcd_fw_cmd_s;

endpackage : dcd_pkg

// ### core/dcd_debug_command_decoder.sv
// Purpose: serial command decode and execution for the debug pin
// Assumes: host starts every bit with a falling edge on the pin
// Notes:   firmware commands are handed to the debug ROM program
//
// How it works
// [RULE1] idle bus cycle, else freeze after 128
// [RULE2] 0x90 requests debug mode if firmware enabled
// [RULE3] E4/EC read with debug resources mapped
// [RULE4] E0/E8 read from application map only
// [RULE5] C4/CC write with debug resources mapped
// [RULE6] C0/C8 write to application map only
// [RULE7] odd byte low lane, even byte high
// [RULE8] host sends word commands word aligned
// [RULE9] debug resources mapped in debug mode, else only during in-map access
// [RULE10] firmware commands only in debug mode
// [RULE11] ROM FF20-FFFF, registers FF00-FF06 when active
// [RULE12] 62..67 firmware reads return 16 bits
// [RULE13] 42..47 firmware writes take 16 bits
// [RULE14] 08 resume, 10 step, 18 tag resume
// [RULE15] opcode then address and/or data
// [RULE16] every read returns 16 data bits
// [RULE17] host waits 150 cycles around access
// [RULE18] host waits 32 cycles before firmware data
// [RULE19] msb first, 512 idle cycles clear command
// [RULE20] bits start on host fall, sample at 10
// [RULE21] no debug mode without enable, hardware ok
// [RULE22] unknown opcodes discarded without access
// [RULE23] firmware opcodes ignored outside debug mode
`timescale 1ns/1ps

module dcd_debug_command_decoder
    import dcd_pkg::*;
(
    // clock and reset
    input  wire logic          clk,
    input  wire logic          rst_n,
    // debug pin, open drain with speed-up
    input  wire logic          debug_pin_in,
    output logic               debug_pin_out,
    output logic               debug_pin_oe,
    // processor state
    input  wire logic          cpu_bus_idle,
    input  wire logic          debug_mode,
    input  wire logic          firmware_enable_bit,
    output logic               cpu_freeze,
    output logic               bg_request,
    output logic               dbg_res_mapped,
    // memory access port
    output dcd_pkg::dcd_mem_req_s mem_req,
    output logic               mem_req_valid,
    input  wire logic          mem_ack,
    input  wire logic [15:0]   mem_rdata,
    // firmware command port
    output dcd_pkg::dcd_fw_cmd_s fw_cmd,
    output logic               fw_cmd_valid,
    input  wire logic          fw_cmd_take,
    input  wire logic          fw_rdata_load,
    input  wire logic [15:0]   fw_rdata
);
    import dcd_pkg::*;

    // ***************************************************************
    // pin synchroniser and edge detect
    // ***************************************************************
    logic        pin_s1_reg;
    logic        pin_s2_reg;
    logic        pin_s3_reg;
    wire  logic  host_fall = pin_s3_reg & ~pin_s2_reg; // RULE20

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_s1_reg <= 1'b1;
            pin_s2_reg <= 1'b1;
            pin_s3_reg <= 1'b1;
        end
        else
        begin
            pin_s1_reg <= debug_pin_in;
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
        end
    end

    // ***************************************************************
    // state and datapath registers
    // ***************************************************************
    dcd_state_e   state_reg;
    logic [9:0]   cyc_reg;
    logic         bit_live_reg;
    logic [4:0]   bits_reg;
    logic [15:0]  shift_reg;
    logic [7:0]   opc_reg;
    logic [15:0]  addr_reg;
    logic [7:0]   steal_reg;
    logic         tx_bit_reg;
    logic         pin_out_reg;
    logic         pin_oe_reg;
    logic         freeze_reg;
    logic         bg_req_reg;
    logic         mapped_reg;
    dcd_mem_req_s mem_req_reg;
    logic         mem_valid_reg;
    dcd_fw_cmd_s  fw_cmd_reg;
    logic         fw_valid_reg;

    // ***************************************************************
    // bit timing
    // ***************************************************************
    wire logic rx_state   = (state_reg == DCD_S_OPC) |
                            (state_reg == DCD_S_ADDR) |
                            (state_reg == DCD_S_WDATA);
    wire logic tx_state   = (state_reg == DCD_S_RDATA);
    wire logic rx_sample  = rx_state & bit_live_reg &
                            (cyc_reg == DCD_SAMPLE_CYC); // RULE20
    wire logic tx_done    = tx_state & bit_live_reg &
                            (cyc_reg == DCD_BITEND_CYC);
    // an access in flight is never abandoned by the link timeout
    wire logic timed_out  = (cyc_reg == DCD_TIMEOUT_CYC) &
                            (state_reg != DCD_S_EXEC) &
                            (state_reg != DCD_S_OPC ||
                             bits_reg != 5'd0); // RULE19
    wire logic [15:0] shift_in = {shift_reg[14:0], pin_s2_reg}; // RULE19
    wire logic [4:0]  bits_inc = bits_reg + 5'd1;
    wire logic opc_full   = rx_sample & (state_reg == DCD_S_OPC) &
                            (bits_inc == DCD_OPC_BITS); // RULE15
    wire logic word_full  = rx_sample & (bits_inc == DCD_WORD_BITS);
    wire logic tx_last    = tx_done & (bits_inc == DCD_WORD_BITS);

    // ***************************************************************
    // opcode decode
    // ***************************************************************
    wire logic [7:0] op_new = shift_in[7:0];
    wire logic op_hw_rd = (op_new == DCD_OP_READ_INMAP_B) |
                          (op_new == DCD_OP_READ_INMAP_W) |
                          (op_new == DCD_OP_READ_B) |
                          (op_new == DCD_OP_READ_W); // RULE3 RULE4
    wire logic op_hw_wr = (op_new == DCD_OP_WRITE_INMAP_B) |
                          (op_new == DCD_OP_WRITE_INMAP_W) |
                          (op_new == DCD_OP_WRITE_B) |
                          (op_new == DCD_OP_WRITE_W); // RULE5 RULE6
    wire logic op_bg    = (op_new == DCD_OP_BACKGROUND);
    wire logic op_fw_rd = (op_new >= DCD_OP_FW_RD_FIRST) &
                          (op_new <= DCD_OP_FW_RD_LAST); // RULE12
    wire logic op_fw_wr = (op_new >= DCD_OP_FW_WR_FIRST) &
                          (op_new <= DCD_OP_FW_WR_LAST); // RULE13
    wire logic op_fw_go = (op_new == DCD_OP_RESUME) |
                          (op_new == DCD_OP_SINGLE_STEP) |
                          (op_new == DCD_OP_TAG_RESUME); // RULE14
    // firmware opcodes count only while the debug ROM is running
    wire logic fw_ok    = debug_mode; // RULE10 RULE23
    wire logic cur_hw   = opc_reg[7];
    wire logic cur_rd   = opc_reg[5];
    wire logic cur_map  = opc_reg[2];
    wire logic cur_word = opc_reg[3];

    // ***************************************************************
    // memory request shaping
    // ***************************************************************
    wire logic steal_now = (steal_reg == DCD_STEAL_CYC - 8'd1);
    wire logic go_access = (state_reg == DCD_S_EXEC) & ~mem_valid_reg &
                           (cpu_bus_idle | steal_now); // RULE1
    wire logic [1:0] lanes = cur_word ? 2'b11 :
                             (addr_reg[0] ? 2'b01 : 2'b10); // RULE7
    wire logic rom_hit = (addr_reg >= DCD_ROM_FIRST) &
                         (addr_reg <= DCD_ROM_LAST); // RULE11
    wire logic reg_hit = (addr_reg >= DCD_REG_FIRST) &
                         (addr_reg <= DCD_REG_LAST); // RULE11
    wire logic [15:0] rd_word =
        cur_word     ? mem_rdata :
        addr_reg[0]  ? {8'h00, mem_rdata[7:0]} :
                       {mem_rdata[15:8], 8'h00}; // RULE7 RULE16
    wire logic mem_done = mem_valid_reg & mem_ack;

    // ***************************************************************
    // pin drive for target-to-host bits
    // ***************************************************************
    wire logic drv_zero  = ~tx_bit_reg & (cyc_reg < DCD_LOW0_CYC);
    wire logic drv_pulse = tx_bit_reg ? (cyc_reg == DCD_SPEEDUP1_CYC) :
                                        (cyc_reg == DCD_LOW0_CYC);
    wire logic drv_on    = tx_state & bit_live_reg & ~host_fall &
                           (drv_zero | drv_pulse);

    // ***************************************************************
    // command sequencer
    // ***************************************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= DCD_S_OPC;
            bits_reg  <= 5'd0;
            shift_reg <= DCD_SHIFT_RST;
            opc_reg   <= 8'h00;
            addr_reg  <= 16'h0000;
        end
        else if (timed_out)
        begin
            state_reg <= DCD_S_OPC; // RULE19
            bits_reg  <= 5'd0;
            opc_reg   <= 8'h00;
        end
        else
        begin
            if (rx_sample)
            begin
                shift_reg <= shift_in;
                bits_reg  <= bits_inc;
            end
            if (tx_done)
            begin
                shift_reg <= {shift_reg[14:0], 1'b0}; // RULE19
                bits_reg  <= bits_inc;
            end
            case (state_reg)
                DCD_S_OPC:
                    if (opc_full)
                    begin
                        opc_reg  <= op_new;
                        bits_reg <= 5'd0;
                        if (op_hw_rd | op_hw_wr)
                            state_reg <= DCD_S_ADDR;
                        else if (op_fw_rd & fw_ok)
                            state_reg <= DCD_S_FWRD;
                        else if (op_fw_wr & fw_ok)
                            state_reg <= DCD_S_WDATA;
                        else
                            state_reg <= DCD_S_OPC; // RULE22
                    end
                DCD_S_ADDR:
                    if (word_full)
                    begin
                        addr_reg  <= shift_in;
                        bits_reg  <= 5'd0;
                        state_reg <= cur_rd ? DCD_S_EXEC : DCD_S_WDATA;
                    end
                DCD_S_WDATA:
                    if (word_full)
                    begin
                        bits_reg  <= 5'd0;
                        state_reg <= cur_hw ? DCD_S_EXEC : DCD_S_OPC;
                    end
                DCD_S_EXEC:
                    if (mem_done)
                    begin
                        shift_reg <= rd_word; // RULE16
                        state_reg <= cur_rd ? DCD_S_RDATA : DCD_S_OPC;
                    end
                DCD_S_FWRD:
                    if (fw_rdata_load)
                    begin
                        shift_reg <= fw_rdata; // RULE12
                        state_reg <= DCD_S_RDATA;
                    end
                DCD_S_RDATA:
                    if (tx_last)
                    begin
                        bits_reg  <= 5'd0;
                        state_reg <= DCD_S_OPC;
                    end
                default:
                    state_reg <= DCD_S_OPC;
            endcase
        end
    end

    // ***************************************************************
    // bit clocking and pin drive
    // ***************************************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cyc_reg      <= 10'd0;
            bit_live_reg <= 1'b0;
            tx_bit_reg   <= 1'b1;
            pin_out_reg  <= 1'b1;
            pin_oe_reg   <= 1'b0;
        end
        else
        begin
            if (host_fall)
            begin
                cyc_reg      <= 10'd0;
                bit_live_reg <= 1'b1;
                tx_bit_reg   <= shift_reg[15]; // RULE19
            end
            else
            begin
                if (cyc_reg != DCD_TIMEOUT_CYC)
                    cyc_reg <= cyc_reg + 10'd1;
                if (rx_sample | tx_done)
                    bit_live_reg <= 1'b0;
            end
            pin_oe_reg  <= drv_on; // RULE20
            pin_out_reg <= drv_pulse;
        end
    end

    // ***************************************************************
    // memory access with cycle stealing
    // ***************************************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            steal_reg     <= 8'd0;
            mem_valid_reg <= 1'b0;
            freeze_reg    <= 1'b0;
            mem_req_reg   <= '0;
        end
        else
        begin
            if (state_reg != DCD_S_EXEC || mem_valid_reg)
                steal_reg <= 8'd0;
            else
                steal_reg <= steal_reg + 8'd1; // RULE1
            if (go_access)
            begin
                mem_valid_reg       <= 1'b1;
                freeze_reg          <= ~cpu_bus_idle; // RULE1
                mem_req_reg.addr    <= addr_reg; // RULE8
                mem_req_reg.wdata   <= shift_reg;
                mem_req_reg.byte_en <= lanes; // RULE7
                mem_req_reg.write   <= ~cur_rd;
                mem_req_reg.inmap   <= cur_map; // RULE3 RULE5
                mem_req_reg.tgt_rom <= cur_map & rom_hit; // RULE4 RULE6
                mem_req_reg.tgt_reg <= cur_map & reg_hit;
            end
            else if (mem_done)
            begin
                mem_valid_reg <= 1'b0;
                freeze_reg    <= 1'b0;
            end
        end
    end

    // ***************************************************************
    // background request, map and firmware hand-off
    // ***************************************************************
    wire logic fw_post = ((state_reg == DCD_S_OPC) & opc_full & fw_ok &
                          (op_fw_rd | op_fw_go)) |
                         ((state_reg == DCD_S_WDATA) & word_full &
                          ~cur_hw); // RULE10 RULE13 RULE14

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bg_req_reg   <= 1'b0;
            mapped_reg   <= 1'b0;
            fw_valid_reg <= 1'b0;
            fw_cmd_reg   <= '0;
        end
        else
        begin
            if ((state_reg == DCD_S_OPC) & opc_full & op_bg &
                firmware_enable_bit & ~timed_out)
                bg_req_reg <= 1'b1; // RULE2 RULE21
            else if (debug_mode)
                bg_req_reg <= 1'b0;
            // debug resources appear throughout debug mode, and otherwise only for an in-map access itself
            mapped_reg <= debug_mode |
                          ((go_access | (mem_valid_reg & ~mem_done)) &
                           (go_access ? cur_map : mem_req_reg.inmap));
                           // RULE9 RULE11
            if (fw_post & ~timed_out)
            begin
                fw_valid_reg      <= 1'b1;
                fw_cmd_reg.opcode <= (state_reg == DCD_S_OPC) ? op_new
                                                              : opc_reg;
                fw_cmd_reg.data   <= shift_in;
            end
            else if (fw_cmd_take)
                fw_valid_reg <= 1'b0;
        end
    end

    assign debug_pin_out  = pin_out_reg;
    assign debug_pin_oe   = pin_oe_reg;
    assign cpu_freeze     = freeze_reg;
    assign bg_request     = bg_req_reg;
    assign dbg_res_mapped = mapped_reg;
    assign mem_req        = mem_req_reg;
    assign mem_req_valid  = mem_valid_reg;
    assign fw_cmd         = fw_cmd_reg;
    assign fw_cmd_valid   = fw_valid_reg;

endmodule : dcd_debug_command_decoder

// ### sim/dcd_chk.sv
// Purpose: port checks for the debug command decoder
// Assumes: one clock domain, bound from the bench
// Notes:   only design-driven signals are judged
`timescale 1ns/1ps

module dcd_chk
    import dcd_pkg::*;
(
    // clock and reset
    input wire logic         clk,
    input wire logic         rst_n,
    // processor side
    input wire logic         cpu_bus_idle,
    input wire logic         debug_mode,
    input wire logic         firmware_enable_bit,
    input wire logic         cpu_freeze,
    input wire logic         bg_request,
    input wire logic         dbg_res_mapped,
    // access and firmware ports
    input dcd_pkg::dcd_mem_req_s mem_req,
    input wire logic         mem_req_valid,
    input wire logic         mem_ack,
    input wire logic         fw_cmd_valid
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ****************
    // properties
    // ****************
    wire vin  = mem_req_valid && mem_req.inmap;
    wire vout = mem_req_valid && !mem_req.inmap;
    wire rom  = mem_req.addr >= DCD_ROM_FIRST;
    wire regs = mem_req.addr >= DCD_REG_FIRST && mem_req.addr <= DCD_REG_LAST;
    sequence s_pend;
        mem_req_valid && !mem_ack;
    endsequence
    sequence s_in2;
        vin ##1 mem_req_valid;
    endsequence
    property p_hold;
        s_pend |=> mem_req_valid && $stable(mem_req);
    endproperty
    a_hold: assert property (p_hold) else $error("request moved");
    property p_freeze;
        $rose(cpu_freeze) |-> mem_req_valid && !$past(cpu_bus_idle);
    endproperty
    a_freeze: assert property (p_freeze) else $error("bad freeze");
    property p_inmap;
        s_in2 |-> dbg_res_mapped;
    endproperty
    a_inmap: assert property (p_inmap) else $error("not mapped");
    property p_outmap;
        vout && !debug_mode && !$past(debug_mode) |-> !dbg_res_mapped;
    endproperty
    a_outmap: assert property (p_outmap) else $error("mapped");
    property p_map;
        vin |-> mem_req.tgt_rom == rom && mem_req.tgt_reg == regs;
    endproperty
    a_map: assert property (p_map) else $error("bad target");
    property p_lane;
        mem_req_valid && mem_req.byte_en != 2'b11
            |-> mem_req.byte_en == (mem_req.addr[0] ? 2'b01 : 2'b10);
    endproperty
    a_lane: assert property (p_lane) else $error("bad lane");
    property p_bg;
        $rose(bg_request) |-> $past(firmware_enable_bit);
    endproperty
    a_bg: assert property (p_bg) else $error("bg not enabled");
    property p_fw;
        $rose(fw_cmd_valid) |-> $past(debug_mode);
    endproperty
    a_fw: assert property (p_fw) else $error("fw outside mode");
endmodule : dcd_chk

// ### sim/dcd_host.sv
// Purpose: host pod model on the debug pin
// Assumes: pin pulls up when nobody drives it
// Notes:   20 clocks a bit, tasks end just after an edge
`timescale 1ns/1ps

module dcd_host (
    // pin
    input  wire logic clk,
    input  wire logic pin,
    output logic      host_low
);
    initial host_low = 1'b0;
    // ****************
    // bit tasks
    // ****************
    task automatic send(input logic [15:0] v, input int n);
        for (int i = n - 1; i >= 0; i--)
        begin
            @(posedge clk) #1 host_low = 1'b1;
            repeat (v[i] ? 4 : 16) @(posedge clk);
            #1 host_low = 1'b0;
            repeat (v[i] ? 15 : 3) @(posedge clk);
        end
        #1;
    endtask : send
    // short low, then leave the line to the target
    task automatic recv(output logic [15:0] v);
        for (int i = 15; i >= 0; i--)
        begin
            @(posedge clk) #1 host_low = 1'b1;
            repeat (4) @(posedge clk);
            #1 host_low = 1'b0;
            repeat (5) @(posedge clk);
            #1 v[i] = pin;
            repeat (10) @(posedge clk);
        end
        #1;
    endtask : recv
endmodule : dcd_host

// ### sim/dcd_debug_command_decoder_test.sv
// Purpose: self-checking bench for the debug command decoder
// Assumes: bench plays memory and firmware, model plays host
// Notes:   hardware commands from a table, the rest by hand
`timescale 1ns/1ps
`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin errors++; \
    $display("[FAIL] %s exp %h got %h", n, e, a); end end

module dcd_debug_command_decoder_test;
    import dcd_pkg::*;
    logic clk, rst_n, cpu_bus_idle, debug_mode, firmware_enable_bit;
    logic mem_ack, fw_cmd_take, fw_rdata_load, host_low, pin_lvl, fz;
    logic debug_pin_out, debug_pin_oe, cpu_freeze, bg_request;
    logic dbg_res_mapped, mem_req_valid, fw_cmd_valid;
    logic [15:0] mem_rdata, fw_rdata, rd, ad;
    logic [7:0]  op;
    logic [1:0]  be;
    dcd_mem_req_s mem_req, cap;
    dcd_fw_cmd_s  fw_cmd, fc;
    int errors = 0;
    int n_checks = 0;
    int cyc = 0;
    // opcode, address, expected lanes
    logic [25:0] rows [8] = '{{8'hE4, 16'hFF21, 2'b01},
        {8'hEC, 16'hFF02, 2'b11}, {8'hE0, 16'h1235, 2'b01},
        {8'hE8, 16'h2000, 2'b11}, {8'hC4, 16'hFF01, 2'b01},
        {8'hCC, 16'hFF20, 2'b11}, {8'hC0, 16'h1234, 2'b10},
        {8'hC8, 16'h0802, 2'b11}};
    // wired-and line, pull-up when released
    assign pin_lvl = host_low ? 1'b0 : (debug_pin_oe ? debug_pin_out : 1'b1);
    dcd_debug_command_decoder i_dut (.clk, .rst_n, .debug_pin_in(pin_lvl),
        .debug_pin_out, .debug_pin_oe, .cpu_bus_idle, .debug_mode,
        .firmware_enable_bit, .cpu_freeze, .bg_request, .dbg_res_mapped,
        .mem_req, .mem_req_valid, .mem_ack, .mem_rdata, .fw_cmd,
        .fw_cmd_valid, .fw_cmd_take, .fw_rdata_load, .fw_rdata);
    dcd_host i_host (.clk, .pin(pin_lvl), .host_low);
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            errors++;
            $display("[FAIL] run time exp %0d got more", 40000);
            close_out();
        end
    end
    // ****************
    // helpers
    // ****************
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    task automatic serve();
        int k;
        k = 0;
        while (mem_req_valid !== 1'b1 && k < 300)
        begin
            step(1);
            k++;
        end
        `CHK("req", 1'b1, mem_req_valid)
        cap = mem_req;
        fz = cpu_freeze;
        mem_ack = 1'b1;
        step(1);
        mem_ack = 1'b0;
    endtask : serve
    task automatic fw_get();
        int k;
        k = 0;
        while (fw_cmd_valid !== 1'b1 && k < 100)
        begin
            step(1);
            k++;
        end
        `CHK("fw", 1'b1, fw_cmd_valid)
        fc = fw_cmd;
        fw_cmd_take = 1'b1;
        step(1);
        fw_cmd_take = 1'b0;
    endtask : fw_get
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : close_out
    // ****************
    // sequence
    // ****************
    initial
    begin
        {rst_n, debug_mode, firmware_enable_bit, mem_ack} = 4'h0;
        {fw_cmd_take, fw_rdata_load, cpu_bus_idle} = 3'b001;
        mem_rdata = 16'hA5C3;
        fw_rdata = 16'h0000;
        step(4);
        `CHK("reset oe", 1'b0, debug_pin_oe)
        rst_n = 1'b1;
        step(3);
        foreach (rows[i])
        begin
            {op, ad, be} = rows[i];
            i_host.send({8'h00, op}, 8);
            i_host.send(ad, 16);
            if (!op[5])
                i_host.send(16'h1256, 16);
            serve();
            `CHK("byte_en", be, cap.byte_en)
            `CHK("inmap", op[2], cap.inmap)
            `CHK("write", ~op[5], cap.write)
            `CHK("addr", ad, cap.addr)
            step(150);
            if (op[5])
                i_host.recv(rd);
            else
                `CHK("wdata", 16'h1256, cap.wdata)
            if (op[5])
                `CHK("rdata", {be[1] ? 8'hA5 : 8'h00, be[0] ? 8'hC3 : 8'h00}, rd)
            $display("row %0d done", i);
        end
        cpu_bus_idle = 1'b0;
        i_host.send(16'h00C0, 8);
        i_host.send(16'h1235, 16);
        i_host.send(16'h0056, 16);
        serve();
        `CHK("freeze", 1'b1, fz)
        cpu_bus_idle = 1'b1;
        $display("steal done");
        i_host.send(16'h0090, 8);
        step(20);
        `CHK("bg off", 1'b0, bg_request)
        firmware_enable_bit = 1'b1;
        i_host.send(16'h0090, 8);
        step(20);
        `CHK("bg on", 1'b1, bg_request)
        debug_mode = 1'b1;
        step(2);
        `CHK("mapped", 1'b1, dbg_res_mapped)
        $display("bg done");
        for (int k = 0; k < 15; k++)
        begin
            op = k < 6 ? 8'(8'h62 + k) : k < 12 ? 8'(8'h3C + k) : 8'(8 * (k - 11));
            i_host.send({8'h00, op}, 8);
            if (k inside {[6:11]})
                i_host.send(16'(16'hBE00 + k), 16);
            fw_get();
            `CHK("fw op", op, fc.opcode)
            if (k inside {[6:11]})
                `CHK("fw data", 16'(16'hBE00 + k), fc.data)
            if (k < 6)
            begin
                fw_rdata = 16'(16'h1230 + k);
                fw_rdata_load = 1'b1;
                step(1);
                fw_rdata_load = 1'b0;
                step(32);
                i_host.recv(rd);
                `CHK("fw rdata", 16'(16'h1230 + k), rd)
            end
            step(64);
        end
        $display("firmware done");
        debug_mode = 1'b0;
        i_host.send(16'h0063, 8);
        step(40);
        `CHK("fw ignored", 1'b0, fw_cmd_valid)
        i_host.send(16'h0009, 4);
        step(600);
        i_host.send(16'h0005, 8);
        step(40);
        `CHK("nop", 1'b0, mem_req_valid | fw_cmd_valid | bg_request)
        $display("refusals done");
        close_out();
    end
endmodule : dcd_debug_command_decoder_test

bind dcd_debug_command_decoder dcd_chk i_chk (.clk, .rst_n, .cpu_bus_idle,
    .debug_mode, .firmware_enable_bit, .cpu_freeze, .bg_request,
    .dbg_res_mapped, .mem_req, .mem_req_valid, .mem_ack, .fw_cmd_valid);
